// File: driver_ctrl_map.svh
// offsets, bit positions and timing constants of the upper control/status bank
//
// Operation
// (R1) status bit 23 always reads one
// (R2) supply over/undervoltage sets bit 22/21, outputs off
// (R3) supply recovery re-enables outputs if bit 20 clear
// (R4) host clears status when latch policy set
// (R5) thermal shutdown sets bit 20, outputs off
// (R6) host clears thermal flag with status-clear bit
// (R7) temperature warning bit 19, informational only
// (R8) standby-to-active starts timer, not-ready bit 18 set
// (R9) not-ready clears itself when start-up time elapses
// (R10) control bit 23 enables; zero gives standby, clears
// (R11) control bit 22 clears status at frame end
// (R12) control bit 21 picks 12 or 25 percent
// (R13) control bits 19:18 steer the current monitor
// (R14) power-up in standby with enable clear
// (R15) effects only after exact 24-bit frame ends
`ifndef DRIVER_CTRL_MAP_SVH
`define DRIVER_CTRL_MAP_SVH

// ****************************************************************
// frame format
// ****************************************************************
`define FRAME_BITS      5'h18
`define FRAME_CNT_MAX   5'h19
`define FRAME_LAST_IDX  5'h17
`define REG_SEL_BIT     0
`define REG_SEL_ZERO    1'h0

// ****************************************************************
// control word (write) field positions
// ****************************************************************
`define CTL_HI          23
`define CTL_LO          18

// ****************************************************************
// status word (read) field positions
// ****************************************************************
`define ST_ALWAYS_ONE   23
`define ST_OV           22
`define ST_UV           21
`define ST_TSD          20
`define ST_TW           19
`define ST_NR           18
`define ST_FAULT_HI     22
`define ST_FAULT_LO     1
`define ST_NO_ERROR     0
`define ST_RESET        24'h00_0000

// ****************************************************************
// synchroniser layout: index 0 is the frame select, reset high
// ****************************************************************
`define SY_CSN          0
`define SY_OV           1
`define SY_UV           2
`define SY_TSD          3
`define SY_TW           4
`define SY_RESET        5'h01

// ****************************************************************
// timing
// ****************************************************************
`define MCLK_HZ         50_000_000
`define STARTUP_US      100
`define STARTUP_CYC     ((`STARTUP_US * (`MCLK_HZ / 1_000_000)))
`define TMR_ZERO        24'h00_0000
`define TMR_ONE         24'h00_0001

`endif

// File: driver_ctrl_pkg.sv
// types shared by the upper control/status bank
package driver_ctrl_pkg;

  // control bits 23..18 as written by the host
  typedef struct packed {
    logic       enable;
    logic       status_clr;
    logic       duty_25;
    logic       supply_latch;
    logic [1:0] mon_sel;
  } ctrl_t;

  // sticky status bits 22..19 and self-clearing not-ready bit 18
  typedef struct packed {
    logic ov;
    logic uv;
    logic overtemp_shutdown_flag;
    logic tw;
    logic nr;
  } status_t;

endpackage

// File: driver_ctrl_status_upper.sv
// serial-link control/status bank for enable, clear, recovery, monitor and fault bits
`timescale 1ns/100ps
`include "driver_ctrl_map.svh"

module driver_ctrl_status_upper #(
  parameter int unsigned STARTUP_CYC = `STARTUP_CYC
) (
  input  wire logic       mclk_i,
  input  wire logic       rstn_i,
  input  wire logic       sclk_i,
  input  wire logic       frame_select_n_i,
  input  wire logic       sdi_i,
  input  wire logic       supply_ov_i,
  input  wire logic       supply_uv_i,
  input  wire logic       overtemp_i,
  input  wire logic       temp_warn_i,
  output logic            sdo_o,
  output logic            sdo_oe_o,
  output logic            outputs_enable_o,
  output logic            standby_o,
  output logic            oc_duty_25_o,
  output logic [1:0]      mon_sel_o
);

  localparam logic [23:0] STARTUP_LAST = 24'(STARTUP_CYC - 1);

  // ****************************************************************
  // link domain: receive shifter on the rising serial clock edge
  // ****************************************************************
  logic        link_rst_n;
  logic        act_r;
  logic [23:0] rx_r;
  logic [23:0] rx_nxt;
  logic [4:0]  cnt_r;
  logic [4:0]  cnt_nxt;
  logic        tog_r;
  logic        tog_nxt;
  logic [23:0] tx_r;
  logic [23:0] tx_nxt;
  logic [4:0]  idx_r;
  logic [4:0]  idx_nxt;
  logic        fall_r;
  logic        sdo_bit_r;
  logic [23:0] snap_r;

  // link logic is held idle while the frame select is high, so no edge is needed at frame end
  assign link_rst_n = rstn_i & ~frame_select_n_i;

  // first-edge flag of the current frame
  always_ff @(posedge sclk_i or negedge link_rst_n) begin
    if (!link_rst_n) begin
      act_r <= 1'b0;
    end else begin
      act_r <= 1'b1;
    end
  end

  // lsb arrives first, so bits enter at the top; count saturates to flag over-long frames
  always_comb begin
    rx_nxt  = {sdi_i, act_r ? rx_r[23:1] : 23'h00_0000};
    cnt_nxt = 5'h01;
    if (act_r) begin
      cnt_nxt = (cnt_r == `FRAME_CNT_MAX) ? cnt_r : cnt_r + 5'h01;
    end
    tx_nxt  = act_r ? tx_r : snap_r;
    // flips once per frame that saw a clock, so a clockless frame cannot reuse the old count
    tog_nxt = act_r ? tog_r : ~tog_r;
  end

  // rx and count survive the frame end so the main domain can take them after it
  always_ff @(posedge sclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rx_r  <= 24'h00_0000;
      cnt_r <= 5'h00;
      tx_r  <= `ST_RESET;
      tog_r <= 1'b0;
    end else begin
      rx_r  <= rx_nxt;
      cnt_r <= cnt_nxt;
      tx_r  <= tx_nxt;
      tog_r <= tog_nxt;
    end
  end

  // ****************************************************************
  // link domain: transmit side on the falling serial clock edge
  // ****************************************************************
  always_comb begin
    idx_nxt = (idx_r == `FRAME_LAST_IDX) ? idx_r : idx_r + 5'h01;
  end

  always_ff @(negedge sclk_i or negedge link_rst_n) begin
    if (!link_rst_n) begin
      idx_r     <= 5'h00;
      fall_r    <= 1'b0;
      sdo_bit_r <= 1'b0;
    end else begin
      idx_r     <= idx_nxt;
      fall_r    <= 1'b1;
      sdo_bit_r <= tx_r[idx_nxt];
    end
  end

  // before the first falling edge the line shows the no-error bit of the snapshot
  assign sdo_o    = fall_r ? sdo_bit_r : snap_r[`ST_NO_ERROR];
  assign sdo_oe_o = ~frame_select_n_i;

  // ****************************************************************
  // main domain: three-stage synchronisers with agreement filter
  // ****************************************************************
  logic [4:0] raw_in;
  logic [4:0] s1_r;
  logic [4:0] s2_r;
  logic [4:0] s3_r;
  logic [4:0] flt_r;
  logic [4:0] flt_nxt;

  assign raw_in = {temp_warn_i, overtemp_i, supply_uv_i, supply_ov_i, frame_select_n_i};

  // a level is accepted only once the second and third stage agree
  genvar g;
  generate
    for (g = 0; g < 5; g++) begin : g_sync
      always_comb begin
        flt_nxt[g] = (s2_r[g] == s3_r[g]) ? s3_r[g] : flt_r[g];
      end
    end
  endgenerate

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s1_r  <= `SY_RESET;
      s2_r  <= `SY_RESET;
      s3_r  <= `SY_RESET;
      flt_r <= `SY_RESET;
    end else begin
      s1_r  <= raw_in;
      s2_r  <= s1_r;
      s3_r  <= s2_r;
      flt_r <= flt_nxt;
    end
  end

  // ****************************************************************
  // main domain: control, status, start-up timer, outputs
  // ****************************************************************
  driver_ctrl_pkg::ctrl_t   ctrl_r;
  driver_ctrl_pkg::ctrl_t   ctrl_nxt;
  driver_ctrl_pkg::ctrl_t   wctl;
  driver_ctrl_pkg::status_t st_r;
  driver_ctrl_pkg::status_t st_nxt;
  logic [23:0]              tmr_r;
  logic [23:0]              tmr_nxt;
  logic                     csn_prev_r;
  logic                     frame_ok;
  logic                     frame_end;
  logic                     tog_seen_r;
  logic                     tog_seen_nxt;
  logic                     supply_block;
  logic                     en_nxt;
  logic [23:0]              snap_nxt;
  logic [23:0]              stat_word;

  assign wctl = driver_ctrl_pkg::ctrl_t'(rx_r[`CTL_HI:`CTL_LO]);

  // rx/cnt are quiet while the frame select is high, so sampling them after its rise is safe
  assign frame_end = flt_r[`SY_CSN] & ~csn_prev_r;
  assign frame_ok  = frame_end & (tog_r != tog_seen_r) & (cnt_r == `FRAME_BITS)
                     & (rx_r[`REG_SEL_BIT] == `REG_SEL_ZERO); // see (R15)

  // status word as the host reads it
  always_comb begin
    stat_word                 = `ST_RESET;
    stat_word[`ST_ALWAYS_ONE] = 1'b1;                      // see (R1)
    stat_word[`ST_OV]         = st_r.ov;
    stat_word[`ST_UV]         = st_r.uv;
    stat_word[`ST_TSD]        = st_r.overtemp_shutdown_flag;
    stat_word[`ST_TW]         = st_r.tw;
    stat_word[`ST_NR]         = st_r.nr;
    stat_word[`ST_NO_ERROR]   = ~|stat_word[`ST_FAULT_HI:`ST_FAULT_LO];
    // snapshot only moves while no frame runs, so the link side reads a steady word
    snap_nxt                  = flt_r[`SY_CSN] ? stat_word : snap_r;
    // every frame end, taken or refused, marks the link toggle as used
    tog_seen_nxt              = frame_end ? tog_r : tog_seen_r;
  end

  // frame commit first, then hardware sets, so an event in the clear cycle survives
  always_comb begin
    ctrl_nxt = ctrl_r;
    st_nxt   = st_r;
    tmr_nxt  = tmr_r;
    if (st_r.nr) begin
      if (tmr_r == STARTUP_LAST) begin
        st_nxt.nr = 1'b0;                                  // see (R9)
      end else begin
        tmr_nxt = tmr_r + `TMR_ONE;
      end
    end
    if (frame_ok) begin
      ctrl_nxt = wctl;                                     // see (R12) (R13)
      if (wctl.status_clr) begin
        st_nxt.ov  = 1'b0;                                 // see (R11) (R4)
        st_nxt.uv  = 1'b0;
        st_nxt.overtemp_shutdown_flag = 1'b0;                                 // see (R6)
        st_nxt.tw  = 1'b0;
      end
      if (!wctl.enable) begin
        ctrl_nxt = '0;                                     // see (R10)
        st_nxt   = '0;
        tmr_nxt  = `TMR_ZERO;
      end else if (!ctrl_r.enable) begin
        st_nxt.nr = 1'b1;                                  // see (R8)
        tmr_nxt   = `TMR_ZERO;
      end
    end
    if (ctrl_nxt.enable) begin
      st_nxt.ov  = st_nxt.ov  | flt_r[`SY_OV];             // see (R2)
      st_nxt.uv  = st_nxt.uv  | flt_r[`SY_UV];             // see (R2)
      st_nxt.overtemp_shutdown_flag = st_nxt.overtemp_shutdown_flag | flt_r[`SY_TSD];            // see (R5)
      st_nxt.tw  = st_nxt.tw  | flt_r[`SY_TW];             // see (R7)
    end
    // latched policy waits for a host clear, otherwise the live level decides
    supply_block = ctrl_nxt.supply_latch ? (st_nxt.ov | st_nxt.uv)
                                         : (flt_r[`SY_OV] | flt_r[`SY_UV]); // see (R3)
    // warning deliberately absent here: it never gates the drivers
    en_nxt = ctrl_nxt.enable & ~st_nxt.nr & ~st_nxt.overtemp_shutdown_flag & ~supply_block; // see (R5) (R8)
  end

  // power-up lands in standby with every bit clear
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctrl_r           <= '0;                              // see (R14)
      st_r             <= '0;
      tmr_r            <= `TMR_ZERO;
      csn_prev_r       <= 1'b1;
      tog_seen_r       <= 1'b0;
      snap_r           <= `ST_RESET;
      outputs_enable_o <= 1'b0;
      standby_o        <= 1'b1;
      oc_duty_25_o     <= 1'b0;
      mon_sel_o        <= 2'h0;
    end else begin
      ctrl_r           <= ctrl_nxt;
      st_r             <= st_nxt;
      tmr_r            <= tmr_nxt;
      csn_prev_r       <= flt_r[`SY_CSN];
      tog_seen_r       <= tog_seen_nxt;
      snap_r           <= snap_nxt;
      outputs_enable_o <= en_nxt;
      standby_o        <= ~ctrl_nxt.enable;                // see (R10)
      oc_duty_25_o     <= ctrl_nxt.duty_25;                // see (R12)
      mon_sel_o        <= ctrl_nxt.mon_sel;                // see (R13)
    end
  end

endmodule

// File: driver_ctrl_status_upper_sva.sv
// port assertions for the upper control/status bank
`timescale 1ns/100ps
module driver_ctrl_status_upper_sva #(
  parameter int unsigned STARTUP_CYC = 20
) (
  input wire logic       mclk_i,
  input wire logic       rstn_i,
  input wire logic       sclk_i,
  input wire logic       frame_select_n_i,
  input wire logic       sdi_i,
  input wire logic       supply_ov_i,
  input wire logic       supply_uv_i,
  input wire logic       overtemp_i,
  input wire logic       temp_warn_i,
  input wire logic       sdo_o,
  input wire logic       sdo_oe_o,
  input wire logic       outputs_enable_o,
  input wire logic       standby_o,
  input wire logic       oc_duty_25_o,
  input wire logic [1:0] mon_sel_o
);
  logic [15:0] up_cnt_r;
  logic [15:0] up_cnt_nxt;
  // cycles since leaving standby; saturates so a long run never wraps
  always_comb begin
    up_cnt_nxt = up_cnt_r;
    if (standby_o) up_cnt_nxt = 16'h0000;
    else if (up_cnt_r != 16'hffff) up_cnt_nxt = up_cnt_r + 16'h0001;
  end
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) up_cnt_r <= 16'h0000;
    else up_cnt_r <= up_cnt_nxt;
  end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  AST_STBY_OFF: assert property (standby_o |-> !outputs_enable_o)
    else $error("outputs enabled in standby");
  AST_STBY_CLR: assert property (standby_o |-> mon_sel_o == 2'h0 && !oc_duty_25_o)
    else $error("control bits kept in standby");
  AST_OV_OFF: assert property (supply_ov_i [*7] |-> !outputs_enable_o)
    else $error("outputs on during overvoltage");
  AST_UV_OFF: assert property (supply_uv_i [*7] |-> !outputs_enable_o)
    else $error("outputs on during undervoltage");
  AST_TSD_OFF: assert property (overtemp_i [*7] |-> !outputs_enable_o)
    else $error("outputs on during thermal shutdown");
  AST_NR_TIME: assert property ($rose(outputs_enable_o) |-> up_cnt_r >= STARTUP_CYC - 1)
    else $error("outputs on before start-up time");
  AST_HOLD: assert property ((!frame_select_n_i) [*6] |->
    $stable({standby_o, oc_duty_25_o, mon_sel_o}))
    else $error("control changed inside a frame");
  AST_AFTER: assert property ($changed({oc_duty_25_o, mon_sel_o}) |->
    $past(frame_select_n_i, 3))
    else $error("control changed without frame end");
  AST_OE_LEVEL: assert property (sdo_oe_o == !frame_select_n_i)
    else $error("data out driver not following frame select");
endmodule

// File: spi_host_model.sv
// host-side serial master on the link, mode 0, lsb first
`timescale 1ns/100ps
module spi_host_model (
  output logic      sclk_o,
  output logic      csn_o,
  output logic      sdi_o,
  input  wire logic sdo_i
);
  initial begin
    sclk_o = 1'h0;
    csn_o = 1'h1;
    sdi_o = 1'h0;
  end
  // n clock pulses; clock stands still outside frames, 80 ns period
  task automatic xfer(input logic [23:0] w, input int n, output logic [23:0] r);
    r = 24'h00_0000;
    csn_o = 1'h0;
    for (int k = 0; k < n; k++) begin
      sdi_o = w[k % 24];
      #40 sclk_o = 1'h1;
      if (k < 24) r[k] = sdo_i;
      #40 sclk_o = 1'h0;
    end
    #40 csn_o = 1'h1;
    sdi_o = ~sdi_o; // released line shows no stale bit
  endtask
endmodule

// File: test_driver_ctrl_status_upper.sv
// self-checking bench for the upper control/status bank
`timescale 1ns/100ps
module test_driver_ctrl_status_upper;
  logic mclk_i, rstn_i, sclk_i, frame_select_n_i, sdi_i, sdo_o, sdo_oe_o;
  logic supply_ov_i, supply_uv_i, overtemp_i, temp_warn_i;
  logic outputs_enable_o, standby_o, oc_duty_25_o;
  logic [1:0] mon_sel_o;
  logic [23:0] rd;
  int n_errors = 0;
  int n_tests = 0;
  // short start-up count keeps the run brief
  localparam int STARTUP = 40;
  driver_ctrl_status_upper #(.STARTUP_CYC(STARTUP)) dut_u (.mclk_i, .rstn_i, .sclk_i,
    .frame_select_n_i, .sdi_i, .supply_ov_i, .supply_uv_i, .overtemp_i, .temp_warn_i,
    .sdo_o, .sdo_oe_o, .outputs_enable_o, .standby_o, .oc_duty_25_o, .mon_sel_o);
  spi_host_model host_u (.sclk_o(sclk_i), .csn_o(frame_select_n_i), .sdi_o(sdi_i),
    .sdo_i(sdo_o));
  // ****************************************
  // helpers
  // ****************************************
  initial begin
    mclk_i = 1'h0;
    forever #10 mclk_i = ~mclk_i;
  end
  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic stop_test;
    $display("comparisons %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
    #2;
  endtask
  // one frame; rd holds the status snapshot taken before the frame
  task automatic fr(input driver_ctrl_pkg::ctrl_t c, input int n = 24);
    tick(1);
    host_u.xfer({c, 17'h0_0000, 1'h0}, n, rd);
    tick(8);
  endtask
  function automatic logic [23:0] st(input driver_ctrl_pkg::status_t s);
    return {1'h1, s, 17'h0_0000, ~|s};
  endfunction
  // ****************************************
  // scenarios
  // ****************************************
  task automatic s_reset;
    chk("standby", 1'h1, standby_o);
    chk("enable", 1'h0, outputs_enable_o);
    chk("sdo_oe", 1'h0, sdo_oe_o);
    fr(6'h00);
    chk("status", st(5'h00), rd);
  endtask
  task automatic s_enable;
    fr(6'h20);
    chk("standby", 1'h0, standby_o);
    chk("enable", 1'h0, outputs_enable_o);
    fr(6'h20);
    chk("status", st(5'h01), rd);
    chk("enable", 1'h1, outputs_enable_o);
    fr(6'h20);
    chk("status", st(5'h00), rd);
  endtask
  task automatic s_ctrl;
    for (int m = 0; m < 8; m++) begin
      fr({1'h1, 1'h0, m[2], 1'h0, m[1:0]});
      chk("duty", m[2], oc_duty_25_o);
      chk("mon", m[1:0], mon_sel_o);
    end
    fr(6'h20, 23);
    fr(6'h20, 25);
    chk("mon", 2'h3, mon_sel_o);
    chk("duty", 1'h1, oc_duty_25_o);
    fr(6'h20);
  endtask
  task automatic s_supply;
    supply_ov_i = 1'h1;
    tick(8);
    chk("enable", 1'h0, outputs_enable_o);
    supply_ov_i = 1'h0;
    fr(6'h20);
    chk("status", st(5'h10), rd);
    chk("enable", 1'h1, outputs_enable_o);
    fr(6'h30);
    fr(6'h24);
    supply_uv_i = 1'h1;
    tick(8);
    supply_uv_i = 1'h0;
    fr(6'h24);
    chk("status", st(5'h08), rd);
    chk("enable", 1'h0, outputs_enable_o);
    fr(6'h34);
    chk("enable", 1'h1, outputs_enable_o);
  endtask
  task automatic s_thermal;
    fr(6'h20);
    overtemp_i = 1'h1;
    tick(8);
    overtemp_i = 1'h0;
    chk("enable", 1'h0, outputs_enable_o);
    fr(6'h20);
    chk("status", st(5'h04), rd);
    chk("enable", 1'h0, outputs_enable_o);
    fr(6'h30);
    chk("enable", 1'h1, outputs_enable_o);
    temp_warn_i = 1'h1;
    tick(8);
    chk("enable", 1'h1, outputs_enable_o);
    temp_warn_i = 1'h0;
    tick(8);
    // a frame with no clock must not replay the earlier status clear
    fr(6'h30, 0);
    fr(6'h20);
    chk("status", st(5'h02), rd);
  endtask
  task automatic s_standby;
    fr(6'h2b);
    fr(6'h00);
    chk("standby", 1'h1, standby_o);
    chk("mon", 2'h0, mon_sel_o);
    fr(6'h00);
    chk("status", st(5'h00), rd);
    // start-up window: commit lands 4 to 5 cycles after the frame ends
    fr(6'h20);
    tick(STARTUP - 5);
    chk("enable", 1'h0, outputs_enable_o);
    tick(4);
    chk("enable", 1'h1, outputs_enable_o);
  endtask
  task automatic s_rerun;
    rstn_i = 1'h0;
    tick(2);
    rstn_i = 1'h1;
    chk("standby", 1'h1, standby_o);
    chk("enable", 1'h0, outputs_enable_o);
    tick(4);
    fr(6'h00);
    chk("status", st(5'h00), rd);
  endtask
  // reset, then every scenario in turn
  initial begin
    rstn_i = 1'h0;
    supply_ov_i = 1'h0;
    supply_uv_i = 1'h0;
    overtemp_i = 1'h0;
    temp_warn_i = 1'h0;
    tick(2);
    rstn_i = 1'h1;
    tick(4);
    s_reset();
    s_enable();
    s_ctrl();
    s_supply();
    s_thermal();
    s_standby();
    s_rerun();
    stop_test();
  end
endmodule
bind driver_ctrl_status_upper driver_ctrl_status_upper_sva #(.STARTUP_CYC(STARTUP_CYC)) sva_u (
  .mclk_i, .rstn_i, .sclk_i, .frame_select_n_i, .sdi_i, .supply_ov_i, .supply_uv_i,
  .overtemp_i, .temp_warn_i, .sdo_o, .sdo_oe_o, .outputs_enable_o, .standby_o,
  .oc_duty_25_o, .mon_sel_o);
